// file: ppg_pkg.sv
/*
  Package for the timer pulse-output block: register offsets, field positions,
  reset values, mode encodings and the packed structs carried between modules.
  Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
package ppg_pkg;
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_CAPCMP = 4'h1;
  localparam logic [3:0] OFS_OUTCTL = 4'h2;
  localparam logic [3:0] OFS_PRESCALE = 4'h3;
  localparam logic [3:0] OFS_CMP_A = 4'h4;
  localparam logic [3:0] OFS_CMP_B = 4'h5;
  localparam logic [3:0] OFS_COUNT = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;

  localparam int RUN_LO = 2;
  localparam int OUT_ENABLE_BIT = 0;
  localparam int OUT_LEVEL_BIT = 1;
  localparam int ONESHOT_EN_BIT = 5;
  localparam int SW_TRIG_BIT = 6;
  localparam int EDGE_LO = 4;
  localparam int PRESC_LO = 0;

  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] OUTCTL_RESET = 8'h00;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CMP_MAX = 16'hFFFF;

  typedef enum logic [1:0] {
    RUN_STOP, RUN_EDGE_CLEAR, RUN_FREE, RUN_MATCH_CLEAR
  } run_mode_e;

  typedef enum logic [1:0] {
    EDGE_FALL, EDGE_RISE, EDGE_NONE, EDGE_BOTH
  } edge_sel_e;

  typedef struct packed {
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    run_mode_e run_mode;
    edge_sel_e edge_sel;
    logic out_enable;
    logic active_low;
    logic oneshot;
    logic [1:0] presc;
  } timer_cfg_s;

  typedef struct packed {
    logic [15:0] count_value;
    logic output_level;
    logic pulse_busy;
  } timer_stat_s;
endpackage

// file: pulse_core.sv
/*
  Counter and output stage: count tick from the prescaler, clear sources,
  compare matches and the pulse output flip-flop.
  Assumes cfg is stable while run mode is nonzero.
*/
`timescale 1ns/10ps
module pulse_core
  import ppg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire ppg_pkg::timer_cfg_s cfg,
  input wire logic sw_trigger,
  input wire logic trigger_input_pin,
  output logic tick,
  output ppg_pkg::timer_stat_s stat
);
  typedef struct packed {
    logic [7:0] div;
    logic [15:0] count;
    logic out;
    logic busy;
    logic pend_sw;
  } core_s;

  core_s st;
  core_s next_st;
  logic ext_hit;
  logic match_a;
  logic match_b;
  logic running;
  logic restart;
  logic b_first;

  trig_edge_detect u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .trigger_input_pin(trigger_input_pin),
    .edge_sel(cfg.edge_sel),
    .edge_hit(ext_hit)
  );

  function automatic logic div_done(input logic [7:0] d, input logic [1:0] p);
    unique case (p)
      2'd0: div_done = 1'b1;
      2'd1: div_done = d[1:0] == 2'b11;
      2'd2: div_done = d[3:0] == 4'hF;
      default: div_done = d == 8'hFF;
    endcase
  endfunction

  always_comb begin
    running = cfg.run_mode != RUN_STOP;
    tick = running && div_done(st.div, cfg.presc);
    match_a = st.count == cfg.compare_a;
    match_b = st.count == cfg.compare_b;
    b_first = cfg.compare_b < cfg.compare_a;
    // match-clear mode never lets a one-shot launch
    restart = cfg.oneshot && cfg.run_mode != RUN_MATCH_CLEAR && st.pend_sw;
    next_st = st;
    next_st.div = running ? st.div + 8'h01 : 8'h00;
    // edge hit lasts one cycle, so hold it until a count tick with any prescaler
    if ((sw_trigger || ext_hit) && running) begin
      next_st.pend_sw = 1'b1;
    end
    if (!running) begin
      next_st.count = 16'h0000;
      next_st.out = 1'b0;
      next_st.busy = 1'b0;
      next_st.pend_sw = 1'b0;
    end else if (tick) begin
      if (restart) begin
        next_st.count = 16'h0000;
        next_st.busy = 1'b1;
        next_st.out = 1'b0;
        // a trigger arriving with the restart tick beats the clear
        next_st.pend_sw = sw_trigger || ext_hit;
      end else if (cfg.oneshot) begin
        next_st.count = st.count + 16'h0001;
        if (st.busy) begin
          if (b_first ? match_b : match_a) begin
            next_st.out = 1'b1;
          end else if (b_first ? match_a : match_b) begin
            next_st.out = 1'b0;
            next_st.busy = 1'b0;
          end
        end
      end else if (cfg.run_mode == RUN_MATCH_CLEAR) begin
        // active while count <= compare_b gives b+1 of a+1 count ticks
        next_st.count = match_a ? 16'h0000 : st.count + 16'h0001;
        next_st.out = match_a || (next_st.count <= cfg.compare_b);
      end else begin
        next_st.count = st.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    stat.count_value = st.count;
    stat.output_level = cfg.out_enable & (st.out ^ cfg.active_low);
    stat.pulse_busy = st.busy;
  end
endmodule

// file: timer_ppg_asserts.sv
/*
  Port checks for the pulse-output top: bus handshake, read-back, pulse timing.
  Assumes bind to the top; timing checks only with prescaler divide 1.
*/
`timescale 1ns/10ps
module timer_ppg_asserts
  import ppg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pulse_output_pin
);
  logic [15:0] cmp_a, cmp_b, hi_len, per_len, since_wr;
  logic [7:0] mode, outctl, presc;
  logic [3:0] wi;
  logic last, done, rd_done, trig_done, base, ppg_on, shot_on;
  assign wi = avs_address[5:2];
  assign done = avs_write && !avs_waitrequest;
  assign rd_done = avs_read && !avs_waitrequest;
  assign trig_done = done && wi == OFS_OUTCTL && avs_writedata[SW_TRIG_BIT];
  assign base = outctl[1:0] == 2'h1 && presc[1:0] == 2'h0;
  assign ppg_on = base && mode[3:2] == 2'h3 && !outctl[ONESHOT_EN_BIT];
  assign shot_on = base && mode[3:2] inside {2'h1, 2'h2} && outctl[ONESHOT_EN_BIT];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {mode, outctl, presc} <= {MODE_RESET, OUTCTL_RESET, PRESC_RESET};
      {cmp_a, cmp_b} <= {CMP_RESET, CMP_RESET};
      {hi_len, per_len, since_wr, last} <= '0;
    end else begin
      if (done && wi == OFS_MODE) mode <= avs_writedata[7:0];
      if (done && wi == OFS_OUTCTL) outctl <= avs_writedata[7:0];
      if (done && wi == OFS_PRESCALE) presc <= avs_writedata[7:0];
      if (done && wi == OFS_CMP_A) cmp_a <= avs_writedata[15:0];
      if (done && wi == OFS_CMP_B) cmp_b <= avs_writedata[15:0];
      // a trigger write leaves the config settled
      since_wr <= (done && !trig_done) ? 16'h0000 : since_wr + {15'h0000, since_wr != 16'hFFFF};
      last <= pulse_output_pin;
      hi_len <= pulse_output_pin ? hi_len + 16'h0001 : 16'h0000;
      per_len <= (pulse_output_pin && !last) ? 16'h0001 : per_len + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in first cycle");
  chk_wait_short: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  chk_rdata_stands: assert property (!avs_read |-> $stable(avs_readdata))
    else $error("readdata moved without a read");
  chk_trig_zero: assert property (rd_done && wi == OFS_OUTCTL |-> !avs_readdata[SW_TRIG_BIT])
    else $error("trigger bit read back as one");
  chk_unmapped_zero: assert property (rd_done && wi > OFS_STATUS |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_ppg_period: assert property (
    $rose(pulse_output_pin) && ppg_on && since_wr > per_len + 16'h0003 |-> per_len == cmp_a + 16'h0001)
    else $error("pulse period wrong");
  chk_ppg_width: assert property (
    $fell(pulse_output_pin) && ppg_on && since_wr > hi_len + 16'h0003 |-> hi_len == cmp_b + 16'h0001)
    else $error("pulse width wrong");
  chk_shot_width: assert property ($fell(pulse_output_pin) && shot_on &&
    since_wr > hi_len + 16'h0003 |-> hi_len == (cmp_a > cmp_b ? cmp_a - cmp_b : cmp_b - cmp_a))
    else $error("single pulse width wrong");
  chk_shot_start: assert property (trig_done && shot_on |-> ##[2:300] $rose(pulse_output_pin))
    else $error("no pulse after trigger");
  cover property ($rose(pulse_output_pin) && ppg_on);
  cover property (trig_done && shot_on);
  cover property ($fell(pulse_output_pin) && shot_on);
endmodule

// file: timer_ppg_oneshot_output.sv
/*
  Top of the timer pulse-output block: Avalon-MM register slave, config
  assembly and the pulse output pin register.
  Assumes a master that holds its request until waitrequest is seen low.
*/
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module timer_ppg_oneshot_output
  import ppg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trigger_input_pin,
  output logic pulse_output_pin
);
  typedef struct packed {
    logic [7:0] mode_control_reg;
    logic [7:0] capcmp_control_reg;
    logic [7:0] output_control_reg;
    logic [7:0] prescaler_mode_reg;
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    logic sw_trig;
    logic ack;
    logic [31:0] rdata;
    logic pin;
  } top_s;

  top_s st;
  top_s next_st;
  timer_cfg_s cfg;
  timer_stat_s stat;
  logic [3:0] idx;
  logic req;

  pulse_core u_core (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(cfg),
    .sw_trigger(st.sw_trig),
    .trigger_input_pin(trigger_input_pin),
    .tick(),
    .stat(stat)
  );

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] wd,
                                        input logic be);
    merge8 = be ? wd : old;
  endfunction

  always_comb begin
    cfg.compare_a = st.compare_a;
    cfg.compare_b = st.compare_b;
    cfg.run_mode = run_mode_e'(st.mode_control_reg[RUN_LO +: 2]);
    cfg.edge_sel = edge_sel_e'(st.prescaler_mode_reg[EDGE_LO +: 2]);
    cfg.out_enable = st.output_control_reg[OUT_ENABLE_BIT];
    cfg.active_low = st.output_control_reg[OUT_LEVEL_BIT];
    cfg.oneshot = st.output_control_reg[ONESHOT_EN_BIT];
    cfg.presc = st.prescaler_mode_reg[PRESC_LO +: 2];
  end

  always_comb begin
    idx = avs_address[5:2];
    req = (avs_read || avs_write) && !st.ack;
    next_st = st;
    next_st.ack = req;
    next_st.sw_trig = 1'b0;
    next_st.pin = stat.output_level;
    if (req && avs_write) begin
      unique case (idx)
        OFS_MODE: next_st.mode_control_reg =
          merge8(st.mode_control_reg, avs_writedata[7:0], avs_byteenable[0]);
        OFS_CAPCMP: next_st.capcmp_control_reg =
          merge8(st.capcmp_control_reg, avs_writedata[7:0], avs_byteenable[0]);
        OFS_OUTCTL: if (avs_byteenable[0]) begin
          next_st.output_control_reg = avs_writedata[7:0];
          next_st.output_control_reg[SW_TRIG_BIT] = 1'b0;
          next_st.sw_trig = avs_writedata[SW_TRIG_BIT];
        end
        OFS_PRESCALE: next_st.prescaler_mode_reg =
          merge8(st.prescaler_mode_reg, avs_writedata[7:0], avs_byteenable[0]);
        OFS_CMP_A: begin
          next_st.compare_a[7:0] = merge8(st.compare_a[7:0], avs_writedata[7:0],
                                          avs_byteenable[0]);
          next_st.compare_a[15:8] = merge8(st.compare_a[15:8], avs_writedata[15:8],
                                           avs_byteenable[1]);
        end
        OFS_CMP_B: begin
          next_st.compare_b[7:0] = merge8(st.compare_b[7:0], avs_writedata[7:0],
                                          avs_byteenable[0]);
          next_st.compare_b[15:8] = merge8(st.compare_b[15:8], avs_writedata[15:8],
                                           avs_byteenable[1]);
        end
        default: ;
      endcase
    end
    if (req && avs_read) begin
      unique case (idx)
        OFS_MODE: next_st.rdata = {24'h00_0000, st.mode_control_reg};
        OFS_CAPCMP: next_st.rdata = {24'h00_0000, st.capcmp_control_reg};
        OFS_OUTCTL: next_st.rdata = {24'h00_0000, st.output_control_reg};
        OFS_PRESCALE: next_st.rdata = {24'h00_0000, st.prescaler_mode_reg};
        OFS_CMP_A: next_st.rdata = {16'h0000, st.compare_a};
        OFS_CMP_B: next_st.rdata = {16'h0000, st.compare_b};
        OFS_COUNT: next_st.rdata = {16'h0000, stat.count_value};
        OFS_STATUS: next_st.rdata = {30'h0000_0000, stat.pulse_busy, stat.output_level};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '{mode_control_reg: MODE_RESET, capcmp_control_reg: 8'h00,
              output_control_reg: OUTCTL_RESET, prescaler_mode_reg: PRESC_RESET,
              compare_a: CMP_RESET, compare_b: CMP_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign avs_readdata = st.rdata;
  assign pulse_output_pin = st.pin;
endmodule

// file: timer_ppg_oneshot_output_bench.sv
/*
  Self-checking bench for the pulse-output block with trig_load as far side.
  Assumes prescaler divide 1, so one count tick per sys_clk.
*/
`timescale 1ns/10ps
module timer_ppg_oneshot_output_bench;
  import ppg_pkg::*;
  logic sys_clk, rst, avs_read, avs_write, trig_req, trig_glitch;
  logic avs_waitrequest, trigger_input_pin, pulse_output_pin;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, p0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int hi_width, period, pulses, a, b;
  int shot_n[4] = '{1, 1, 0, 2};
  logic [3:0] r_ofs[6] = '{OFS_MODE, OFS_OUTCTL, OFS_PRESCALE, OFS_CMP_A, OFS_CMP_B, 4'hF};
  logic [31:0] r_val[6] = '{32'(MODE_RESET), 32'(OUTCTL_RESET), 32'(PRESC_RESET),
    32'(CMP_RESET), 32'(CMP_RESET), 32'h0000_0000};
  timer_ppg_oneshot_output uut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .trigger_input_pin, .pulse_output_pin);
  trig_load partner (.sys_clk, .pulse_output_pin, .trig_req, .trig_glitch,
    .trigger_input_pin, .hi_width, .period, .pulses);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task stop_test;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // request stands until the rising edge that samples waitrequest low; watchdog ends a hang
  task bus(input logic wr, input logic [3:0] ofs, input logic [31:0] wd);
    avs_address <= {ofs, 2'b00};
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // next edge only after the pulse has ended
  task poke(input logic g);
    if (g) trig_glitch <= 1'b1;
    else trig_req <= 1'b1;
    @(posedge sys_clk);
    {trig_glitch, trig_req} <= 2'h0;
    repeat (a + b + 20) @(posedge sys_clk);
  endtask
  task setup(input logic [31:0] outc, input logic [31:0] pre, input logic [31:0] run);
    bus(1, OFS_MODE, 0);
    if (outc[ONESHOT_EN_BIT]) begin
      bus(1, OFS_PRESCALE, pre);
      bus(1, OFS_CAPCMP, 0);
      bus(1, OFS_OUTCTL, outc);
    end else begin
      bus(1, OFS_CAPCMP, 0);
    end
    bus(1, OFS_CMP_A, a);
    bus(1, OFS_CMP_B, b);
    if (!outc[ONESHOT_EN_BIT]) begin
      bus(1, OFS_OUTCTL, outc);
      bus(1, OFS_PRESCALE, pre);
    end
    bus(1, OFS_MODE, run);
  endtask
  initial begin
    #(25 * 30000);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end
  initial begin
    {rst, avs_read, avs_write, trig_req, trig_glitch} = 5'h10;
    {avs_address, avs_writedata} = '0;
    void'($urandom(75953));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(1, 4'hF, 32'hFFFF_FFFF);
    foreach (r_ofs[i]) begin
      bus(0, r_ofs[i], 0);
      check(rd, r_val[i]);
    end
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      a = 8 + $urandom % 32;
      b = 1 + $urandom % (a - 1);
      setup(i ? 3 : 1, 0, 32'h0000_000C);
      repeat (3 * a + 20) @(posedge sys_clk);
      check(period, a + 1);
      check(hi_width, i ? a - b : b + 1);
    end
    bus(1, OFS_MODE, 0);
    bus(0, OFS_COUNT, 0);
    p0 = rd;
    repeat (5) @(posedge sys_clk);
    bus(0, OFS_COUNT, 0);
    check(rd, p0);
    $display("pulse test done");
    for (int i = 0; i < 2; i++) begin
      a = 8 + $urandom % 32;
      b = i ? a + 1 + $urandom % 8 : 1 + $urandom % (a - 1);
      setup(32'h0000_0021, 0, 32'h0000_0008);
      p0 = pulses;
      bus(1, OFS_OUTCTL, 32'h0000_0061);
      repeat (a + b + 20) @(posedge sys_clk);
      check(hi_width, i ? b - a : a - b);
      check(pulses, p0 + 1);
      bus(0, OFS_OUTCTL, 0);
      check(rd[SW_TRIG_BIT], 1'b0);
      bus(0, OFS_COUNT, 0);
      p0 = rd;
      bus(0, OFS_COUNT, 0);
      check(rd == p0, 1'b0);
    end
    $display("software shot test done");
    for (int e = 0; e < 4; e++) begin
      a = 12;
      b = 5;
      setup(32'h0000_0021, e << EDGE_LO, e[0] ? 4 : 8);
      p0 = pulses;
      poke(0);
      poke(0);
      poke(1);
      check(pulses, p0 + shot_n[e]);
      if (shot_n[e] > 0) check(hi_width, a - b);
    end
    $display("external shot test done");
    setup(32'h0000_0021, 0, 32'h0000_000C);
    p0 = pulses;
    bus(1, OFS_OUTCTL, 32'h0000_0061);
    repeat (a + b + 20) @(posedge sys_clk);
    check(pulses, p0);
    $display("match-clear shot test done");
    stop_test;
  end
endmodule
bind timer_ppg_oneshot_output timer_ppg_asserts chk (.*);

// file: trig_edge_detect.sv
/*
  Edge detector for the trigger input pin: two-flop synchroniser on sys_clk,
  then sampled on each count tick with a two-sample agreement filter.
  Assumes tick is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/10ps
module trig_edge_detect
  import ppg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic trigger_input_pin,
  input wire ppg_pkg::edge_sel_e edge_sel,
  output logic edge_hit
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic samp;
    logic level;
    logic hit;
  } det_s;

  det_s st;
  det_s next_st;
  logic rise;
  logic fall;

  always_comb begin
    next_st = st;
    next_st.meta = trigger_input_pin;
    next_st.sync = st.meta;
    next_st.hit = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    if (tick) begin
      next_st.samp = st.sync;
      // new level must appear on two consecutive samples
      if (st.samp == st.sync && st.sync != st.level) begin
        next_st.level = st.sync;
        rise = st.sync;
        fall = !st.sync;
      end
      unique case (edge_sel)
        EDGE_RISE: next_st.hit = rise;
        EDGE_FALL: next_st.hit = fall;
        EDGE_BOTH: next_st.hit = rise | fall;
        EDGE_NONE: next_st.hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign edge_hit = st.hit;
endmodule

// file: trig_load.sv
/*
  Far side model: drives the trigger pin and measures the pulse output.
  Assumes one-cycle request pulses from the bench on sys_clk.
*/
`timescale 1ns/10ps
module trig_load (
  input wire logic sys_clk,
  input wire logic pulse_output_pin,
  input wire logic trig_req,
  input wire logic trig_glitch,
  output logic trigger_input_pin,
  output int hi_width,
  output int period,
  output int pulses
);
  int hi_run = 0;
  int per_run = 0;
  logic last = 1'b0;
  logic glitch_d = 1'b0;
  initial begin
    trigger_input_pin = 1'b0;
    hi_width = 0;
    period = 0;
    pulses = 0;
  end
  always @(posedge sys_clk) begin
    glitch_d <= trig_glitch;
    // a glitch flips back next cycle, too short for the edge filter
    if (trig_req || trig_glitch || glitch_d) trigger_input_pin <= ~trigger_input_pin;
    last <= pulse_output_pin;
    hi_run <= pulse_output_pin ? hi_run + 1 : 0;
    if (!pulse_output_pin && last) hi_width <= hi_run;
    if (pulse_output_pin && !last) begin
      period <= per_run;
      pulses <= pulses + 1;
    end
    per_run <= (pulse_output_pin && !last) ? 1 : per_run + 1;
  end
endmodule
